// ===== logic/pmd_map.svh
// Purpose: Offsets, field positions, reset values and boundaries of the mode decoder
// Assumes: Included by the package and by the top module
// Notes: Byte addresses on a 32-bit slave, one word per register
`ifndef PMD_MAP_SVH
`define PMD_MAP_SVH
// ==========================================================
// Register offsets
`define PMD_CFG_OFS 4'h0
`define PMD_MEMCTL_OFS 4'h4
`define PMD_STATUS_OFS 4'h8
`define PMD_VARIANT_OFS 4'hC
// ==========================================================
// Reset values and masks
`define PMD_CFG_RST 8'h83
`define PMD_CFG_WMASK 8'h83
`define PMD_MEMCTL_RST 8'h00
`define PMD_MEMCTL_WMASK 8'h30
`define PMD_VARIANT_RST 8'h05
`define PMD_VARIANT_WMASK 8'h07
// ==========================================================
// Field positions
`define PMD_WAIT_EN_BIT 7
`define PMD_MODE_LSB 0
`define PMD_WCNT_LSB 4
`define PMD_EXT_BIT 0
`define PMD_SIZE_LSB 1
`define PMD_STAT_BUSY_BIT 2
// ==========================================================
// Mode codes
`define PMD_MODE_INT_ONLY 2'h3
`define PMD_MODE_EXT_ONLY 2'h2
`define PMD_MODE_BOOT_EXT 2'h1
`define PMD_MODE_EXTENDED 2'h0
// ==========================================================
// Flash sizes and address boundaries
`define PMD_SIZE_32K 2'h0
`define PMD_SIZE_64K 2'h1
`define PMD_SIZE_128K 2'h2
`define PMD_BOOT_SMALL 21'h0007FF
`define PMD_BOOT_LARGE 21'h0001FF
`define PMD_LIMIT_32K 21'h007FFF
`define PMD_LIMIT_64K 21'h00FFFF
`define PMD_LIMIT_128K 21'h01FFFF
`endif

// ===== logic/pmd_pkg.sv
// Purpose: Types shared by the mode decoder modules
// Assumes: Map header holds the mode codes; target, kind and wait-state codes are set here
// Notes: None
`include "pmd_map.svh"
package pmd_pkg;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    internal_only_mode = `PMD_MODE_INT_ONLY,
    external_only_mode = `PMD_MODE_EXT_ONLY,
    boot_block_external_mode = `PMD_MODE_BOOT_EXT,
    extended_internal_external_mode = `PMD_MODE_EXTENDED
  } pmd_mode_t;
  typedef enum logic [1:0] {
    tgt_none = 2'h0,
    tgt_internal = 2'h1,
    tgt_external = 2'h2,
    tgt_zero = 2'h3
  } pmd_target_t;
  typedef enum logic [1:0] {
    kind_fetch = 2'h0,
    kind_table_read = 2'h1,
    kind_table_write = 2'h2
  } pmd_kind_t;
  typedef enum logic [1:0] {
    w_idle = 2'h0,
    w_hold = 2'h1
  } pmd_wstate_t;
endpackage

// ===== logic/pmd_wait_if.sv
// Purpose: Carries a wait-state request from the decoder to its timer
// Assumes: Single clock
// Notes: None
interface pmd_wait_if;
  logic start;
  logic [1:0] count;
  logic busy;
  modport ctrl (output start, output count, input busy);
  modport timer (input start, input count, output busy);
endinterface

// ===== logic/pmd_wait.sv
// Purpose: Counts external-bus wait states for one access
// Assumes: No start arrives while busy
// Notes: Busy stands for exactly count cycles after the start edge
module pmd_wait
  import pmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  pmd_wait_if.timer w
);
  pmd_wstate_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;

  // ==========================================================
  // Next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      w_idle: begin
        if (w.start && (w.count != 2'h0)) begin
          state_d = w_hold;
          cnt_d = w.count - 2'h1;
        end
      end
      w_hold: begin
        if (cnt_q == 2'h0) begin
          state_d = w_idle;
        end else begin
          cnt_d = cnt_q - 2'h1;
        end
      end
      default: state_d = w_idle;
    endcase
    busy_d = (state_d == w_hold);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= w_idle;
      cnt_q <= 2'h0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign w.busy = busy_q;

  // ==========================================================
  // Checks
  wait_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    w.start && !busy_q && w.count == 2'h2 |=> busy_q ##1 busy_q ##1 !busy_q)
    else $error("wait count of two not held two cycles");
  wait_none_a: assert property (@(posedge clk) disable iff (!rst_n)
    w.start && !busy_q && w.count == 2'h0 |=> !busy_q)
    else $error("zero wait count raised busy");
endmodule

// ===== logic/pmd_top.sv
// Purpose: Program-memory mode decode and address steering, register slave on Avalon-MM
// Assumes: Requester holds off new accesses while ext_wait is high
// Notes: Routing decision is registered; outputs follow the accepting edge
`include "pmd_map.svh"

// Contract
// - Mode field 11 internal-only, 10 external-only, 01 boot-block, 00 extended.
// - External-only mode sends all accesses out over a 21-bit linear space.
// - External-only mode ignores flash fully: no fetch, table read or write inside.
// - Boot-block mode serves addresses up to the boot boundary inside, rest outside.
// - Internal-only mode uses flash; reads above the flash limit return zeros.
// - Extended mode maps all flash from zero, higher addresses go outside.
// - Mixed modes switch between memories by address with no software action.
// - Data RAM and data EEPROM access stays intact in every mode.
// - Parts without an external bus run internal-only whatever the field holds.
// - Wait enable bit 7 set means no waits; clear uses the programmed count.
// - Configuration bits 6 to 2 read as zero.
// - Wait enable and mode bits come up as ones, internal-only with no waits.
module pmd_top
  import pmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic acc_valid,
  input wire logic [1:0] acc_kind,
  input wire logic [20:0] acc_addr,
  input wire logic data_req,
  output logic int_req,
  output logic ext_req,
  output logic zero_fill,
  output logic mem_write,
  output logic [20:0] mem_addr,
  output logic ext_wait,
  output logic data_ack
);
  // ==========================================================
  // Declarations
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] memctl_q, memctl_d;
  logic [7:0] variant_q, variant_d;
  logic waitreq_q, waitreq_d;
  logic [31:0] rdata_q, rdata_d;
  logic int_req_q, int_req_d;
  logic ext_req_q, ext_req_d;
  logic zero_q, zero_d;
  logic write_q, write_d;
  logic [20:0] addr_q, addr_d;
  logic data_ack_q, data_ack_d;
  logic has_ext;
  logic [1:0] size_sel;
  logic [1:0] wait_cnt;
  logic accept;
  logic is_write;
  logic bus_commit;
  pmd_mode_t eff_mode;
  pmd_target_t tgt;
  pmd_wait_if wif ();

  // ==========================================================
  // Boundary functions
  function automatic logic [20:0] flash_limit(input logic [1:0] size);
    logic [20:0] lim;
    lim = `PMD_LIMIT_128K;
    if (size == `PMD_SIZE_32K) begin
      lim = `PMD_LIMIT_32K;
    end else if (size == `PMD_SIZE_64K) begin
      lim = `PMD_LIMIT_64K;
    end
    return lim;
  endfunction

  function automatic logic [20:0] boot_limit(input logic [1:0] size);
    logic [20:0] lim;
    lim = `PMD_BOOT_LARGE;
    if (size == `PMD_SIZE_32K) begin
      lim = `PMD_BOOT_SMALL;
    end
    return lim;
  endfunction

  // Address compare against the selected mode's map
  function automatic pmd_target_t route(input pmd_mode_t mode, input logic [1:0] size,
                                        input logic [20:0] addr, input logic wr);
    pmd_target_t t;
    t = tgt_none;
    case (mode)
      external_only_mode: t = tgt_external;
      boot_block_external_mode: begin
        t = (addr <= boot_limit(size)) ? tgt_internal : tgt_external;
      end
      extended_internal_external_mode: begin
        t = (addr <= flash_limit(size)) ? tgt_internal : tgt_external;
      end
      default: begin
        // Writes above flash go nowhere; reads return a no-operation word
        if (addr <= flash_limit(size)) begin
          t = tgt_internal;
        end else begin
          t = wr ? tgt_none : tgt_zero;
        end
      end
    endcase
    return t;
  endfunction

  // ==========================================================
  // Mode and wait decode
  always_comb begin
    has_ext = variant_q[`PMD_EXT_BIT];
    size_sel = variant_q[`PMD_SIZE_LSB +: 2];
    // Bus-less parts ignore the field entirely
    eff_mode = has_ext ? pmd_mode_t'(cfg_q[`PMD_MODE_LSB +: 2])
                       : internal_only_mode;
    wait_cnt = cfg_q[`PMD_WAIT_EN_BIT] ? 2'h0 : memctl_q[`PMD_WCNT_LSB +: 2];
    is_write = (acc_kind == kind_table_write);
    accept = acc_valid && !wif.busy;
    tgt = route(eff_mode, size_sel, acc_addr, is_write);
  end

  assign wif.start = accept && (tgt == tgt_external);
  assign wif.count = wait_cnt;

  pmd_wait u_wait (
    .clk(clk),
    .rst_n(rst_n),
    .w(wif)
  );

  // ==========================================================
  // Steering outputs
  always_comb begin
    int_req_d = accept && (tgt == tgt_internal);
    ext_req_d = accept && (tgt == tgt_external);
    zero_d = accept && (tgt == tgt_zero);
    write_d = accept && is_write && (tgt != tgt_none);
    addr_d = accept ? acc_addr : addr_q;
    // Data side never depends on the program map
    data_ack_d = data_req;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_req_q <= 1'b0;
      ext_req_q <= 1'b0;
      zero_q <= 1'b0;
      write_q <= 1'b0;
      addr_q <= 21'h000000;
      data_ack_q <= 1'b0;
    end else begin
      int_req_q <= int_req_d;
      ext_req_q <= ext_req_d;
      zero_q <= zero_d;
      write_q <= write_d;
      addr_q <= addr_d;
      data_ack_q <= data_ack_d;
    end
  end

  // ==========================================================
  // Register slave
  // One wait cycle per access keeps read data a clean flop output
  always_comb begin
    waitreq_d = !((avs_read || avs_write) && waitreq_q);
    bus_commit = avs_write && !waitreq_q;
    cfg_d = cfg_q;
    memctl_d = memctl_q;
    variant_d = variant_q;
    rdata_d = rdata_q;
    if (bus_commit && avs_byteenable[0]) begin
      if (avs_address == `PMD_CFG_OFS) begin
        cfg_d = avs_writedata[7:0] & `PMD_CFG_WMASK;
      end else if (avs_address == `PMD_MEMCTL_OFS) begin
        memctl_d = avs_writedata[7:0] & `PMD_MEMCTL_WMASK;
      end else if (avs_address == `PMD_VARIANT_OFS) begin
        variant_d = avs_writedata[7:0] & `PMD_VARIANT_WMASK;
      end
    end
    if (avs_read && waitreq_q) begin
      rdata_d = 32'h00000000;
      if (avs_address == `PMD_CFG_OFS) begin
        rdata_d[7:0] = cfg_q & `PMD_CFG_WMASK;
      end else if (avs_address == `PMD_MEMCTL_OFS) begin
        rdata_d[7:0] = memctl_q;
      end else if (avs_address == `PMD_STATUS_OFS) begin
        rdata_d[1:0] = eff_mode;
        rdata_d[`PMD_STAT_BUSY_BIT] = wif.busy;
        rdata_d[`PMD_WCNT_LSB +: 2] = wait_cnt;
      end else if (avs_address == `PMD_VARIANT_OFS) begin
        rdata_d[7:0] = variant_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q <= `PMD_CFG_RST;
      memctl_q <= `PMD_MEMCTL_RST;
      variant_q <= `PMD_VARIANT_RST;
      waitreq_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      cfg_q <= cfg_d;
      memctl_q <= memctl_d;
      variant_q <= variant_d;
      waitreq_q <= waitreq_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = waitreq_q;
  assign int_req = int_req_q;
  assign ext_req = ext_req_q;
  assign zero_fill = zero_q;
  assign mem_write = write_q;
  assign mem_addr = addr_q;
  assign ext_wait = wif.busy;
  assign data_ack = data_ack_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  mode_decode_a: assert property (
    has_ext && cfg_q[1:0] == 2'h1 && accept && acc_addr == 21'h000000 |=> int_req_q)
    else $error("boot-block code did not serve address zero inside");
  ext_only_route_a: assert property (
    accept && eff_mode == external_only_mode |=> ext_req_q && mem_addr == $past(acc_addr))
    else $error("external-only access not sent out");
  ext_only_flash_a: assert property (
    eff_mode == external_only_mode && accept |=> !int_req_q && !zero_q)
    else $error("flash touched in external-only mode");
  boot_split_a: assert property (
    accept && eff_mode == boot_block_external_mode && size_sel == 2'h0
    && acc_addr == 21'h000800 |=> ext_req_q && !int_req_q)
    else $error("first address past boot block not external");
  int_only_nop_a: assert property (
    accept && eff_mode == internal_only_mode && !is_write
    && acc_addr > flash_limit(size_sel) |=> zero_fill && !ext_req && !int_req)
    else $error("read above flash did not return zeros");
  extended_split_a: assert property (
    accept && eff_mode == extended_internal_external_mode && size_sel == 2'h1
    && acc_addr == 21'h010000 |=> ext_req_q)
    else $error("extended mode missed external past flash");
  mixed_switch_a: assert property (
    accept && eff_mode == extended_internal_external_mode
    && acc_addr <= flash_limit(size_sel) |=> int_req_q ##0 !ext_req_q)
    else $error("extended mode missed internal flash");
  data_path_a: assert property (
    data_req |=> data_ack)
    else $error("data access blocked");
  no_bus_a: assert property (
    !has_ext && accept |=> !ext_req_q && !ext_wait)
    else $error("bus-less part went external");
  wait_off_a: assert property (
    accept && tgt == tgt_external && cfg_q[7] |=> ext_req_q && !ext_wait)
    else $error("wait states with wait enable set");
  cfg_zero_a: assert property (
    avs_read && waitreq_q && avs_address == 4'h0 |=> avs_readdata[6:2] == 5'h00)
    else $error("unimplemented bits read nonzero");
  erased_a: assert property (
    $rose(rst_n) |-> cfg_q == 8'h83)
    else $error("configuration not erased after reset");
  steer_now_a: assert property (
    accept && !(eff_mode == internal_only_mode && is_write
    && acc_addr > flash_limit(size_sel)) |=> $onehot({int_req_q, ext_req_q, zero_q}))
    else $error("accepted access not steered");
  wait_on_a: assert property (
    accept && tgt == tgt_external && !cfg_q[7] && memctl_q[5:4] != 2'h0
    |=> ext_req_q && ext_wait)
    else $error("programmed wait states not inserted");
  // Requests during wait states leave no trace on the steering outputs
  wait_refuse_a: assert property (
    acc_valid && ext_wait |=> !int_req_q && !ext_req_q && !zero_q)
    else $error("request accepted during wait states");
  table_write_a: assert property (
    write_q |-> int_req_q || ext_req_q)
    else $error("table write pulse without a target");
  cfg_write_a: assert property (
    bus_commit && avs_address == 4'h0 |=> cfg_q[6:2] == 5'h00)
    else $error("unimplemented bits stored");
  data_idle_a: assert property (
    !data_req |=> !data_ack)
    else $error("data acknowledged without request");

  // ==========================================================
  // Scenario covers
  cov_ext_only_c: cover property (accept && eff_mode == external_only_mode);
  cov_boot_c: cover property (accept && eff_mode == boot_block_external_mode ##1 ext_req_q);
  cov_zero_c: cover property (zero_fill);
  cov_wait_c: cover property (ext_req_q && ext_wait);
  cov_refuse_c: cover property (acc_valid && ext_wait);
endmodule

// ===== verification/pmd_ext_mem.sv
// Purpose: External program memory on the far side of the steering block
// Assumes: Each external access shows as a one-cycle ext_req pulse
// Notes: Only the traffic is logged; no data path is modelled
module pmd_ext_mem
  import pmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_req,
  input wire logic mem_write,
  output int n_acc,
  output int n_wr
);
  // ==========================================================
  // Access log
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      n_acc <= 0;
      n_wr <= 0;
    end else if (ext_req) begin
      n_acc <= n_acc + 1;
      n_wr <= n_wr + int'(mem_write);
    end
  end
endmodule

// ===== verification/pmd_top_test.sv
// Purpose: Self-checking bench for the program-memory mode decoder
// Assumes: Register bus answers whenever waitrequest drops; a hang is left to the watchdog
// Notes: Expected routes come from a bench model, never from the design
module pmd_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pmd_pkg::*;
  logic clk, rst_n, avs_read, avs_write, acc_valid, data_req;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic avs_waitrequest, int_req, ext_req, zero_fill, mem_write, ext_wait, data_ack;
  logic [1:0] acc_kind;
  logic [20:0] acc_addr, mem_addr;
  int failures, n_compared, ext_exp, wr_exp, n_acc, n_wr;
  // ==========================================================
  // Design and far side
  pmd_top u_pmd_top (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .acc_valid(acc_valid), .acc_kind(acc_kind),
    .acc_addr(acc_addr), .data_req(data_req), .int_req(int_req), .ext_req(ext_req),
    .zero_fill(zero_fill), .mem_write(mem_write), .mem_addr(mem_addr),
    .ext_wait(ext_wait), .data_ack(data_ack));
  pmd_ext_mem u_pmd_ext_mem (.clk(clk), .rst_n(rst_n), .ext_req(ext_req),
    .mem_write(mem_write), .n_acc(n_acc), .n_wr(n_wr));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Waits for the edge that samples waitrequest low
  task automatic bus_wait();
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait();
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic acc(input logic [1:0] k, input logic [20:0] a, input logic [3:0] e);
    acc_valid <= 1'b1;
    acc_kind <= k;
    acc_addr <= a;
    @(posedge clk);
    acc_valid <= 1'b0;
    #1;
    chk({28'h0, int_req, ext_req, zero_fill, mem_write}, {28'h0, e});
    if (e[3] | e[2]) chk({11'h0, mem_addr}, {11'h0, a});
    if (e[2]) ext_exp++;
    if (e[2] & e[0]) wr_exp++;
    @(posedge clk);
  endtask
  task automatic data_chk();
    data_req <= 1'b1;
    @(posedge clk);
    data_req <= 1'b0;
    #1;
    chk({31'h0, data_ack}, 32'h1);
    @(posedge clk);
  endtask
  // Route as {internal, external, zero, write}
  function automatic logic [3:0] route(pmd_mode_t m, logic [20:0] lim, logic [20:0] boot,
                                       logic ext, logic [1:0] k, logic [20:0] a);
    logic wr;
    wr = (k == 2'h2);
    if (!ext) m = internal_only_mode;
    case (m)
      internal_only_mode: return (a <= lim) ? {3'b100, wr} : (wr ? 4'h0 : 4'h2);
      external_only_mode: return {3'b010, wr};
      boot_block_external_mode: return (a <= boot) ? {3'b100, wr} : {3'b010, wr};
      default: return (a <= lim) ? {3'b100, wr} : {3'b010, wr};
    endcase
  endfunction
  // ==========================================================
  // Scenarios
  task automatic test_regs();
    bus_rd(4'h0, rd);
    chk(rd, 32'h83);
    bus_rd(4'h4, rd);
    chk(rd, 32'h0);
    bus_rd(4'hC, rd);
    chk(rd, 32'h5);
    bus_rd(4'h2, rd);
    chk(rd, 32'h0);
    bus_wr(4'h0, 8'h7C);
    bus_rd(4'h0, rd);
    chk(rd, 32'h0);
    avs_byteenable <= 4'h0;
    bus_wr(4'h0, 8'h83);
    avs_byteenable <= 4'hF;
    bus_rd(4'h0, rd);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask
  // Every mode, kind and boundary on four part variants
  task automatic test_routes();
    logic [7:0] vt [4] = '{8'h05, 8'h01, 8'h04, 8'h03};
    logic [20:0] lim, boot;
    logic [20:0] ad [6];
    for (int v = 0; v < 4; v++) begin
      bus_wr(4'hC, vt[v]);
      lim = (vt[v][2:1] == 2'h0) ? 21'h007FFF : 21'h01FFFF;
      if (vt[v][2:1] == 2'h1) lim = 21'h00FFFF;
      boot = (vt[v][2:1] == 2'h0) ? 21'h0007FF : 21'h0001FF;
      ad = '{21'h0, boot, boot + 21'h1, lim, lim + 21'h1, 21'h1FFFFE};
      for (int m = 0; m < 4; m++) begin
        bus_wr(4'h0, {6'h20, 2'(m)});
        bus_rd(4'h8, rd);
        chk({30'h0, rd[1:0]}, vt[v][0] ? 32'(m) : 32'h3);
        data_chk();
        for (int i = 0; i < 6; i++) begin
          for (int k = 0; k < 3; k++) begin
            acc(2'(k), ad[i], route(pmd_mode_t'(m), lim, boot, vt[v][0], 2'(k), ad[i]));
          end
        end
      end
    end
    $display("test routes done");
  endtask
  // Wait states counted, and a request inside them refused
  task automatic wait_run(input int exp_n);
    int n;
    logic ir;
    n = 0;
    ir = 1'b0;
    acc_valid <= 1'b1;
    acc_kind <= 2'h0;
    acc_addr <= 21'h020000;
    @(posedge clk);
    acc_addr <= 21'h0;
    acc_valid <= (exp_n != 0);
    repeat (6) begin
      #1;
      if (ext_wait === 1'b1) n++;
      if (int_req === 1'b1) ir = 1'b1;
      @(posedge clk);
      acc_valid <= 1'b0;
    end
    chk(32'(n), 32'(exp_n));
    chk({31'h0, ir}, 32'h0);
    ext_exp++;
  endtask
  task automatic test_wait();
    bus_wr(4'hC, 8'h05);
    bus_wr(4'h0, 8'h00);
    for (int c = 0; c < 4; c++) begin
      bus_wr(4'h4, {2'h0, 2'(c), 4'h0});
      bus_rd(4'h8, rd);
      chk(rd, {26'h0, 2'(c), 4'h0});
      wait_run(c);
    end
    bus_wr(4'h0, 8'h80);
    bus_rd(4'h8, rd);
    chk(rd, 32'h0);
    wait_run(0);
    $display("test wait done");
  endtask
  // Mid-run reset brings the erased configuration back
  task automatic test_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({31'h0, avs_waitrequest}, 32'h1);
    bus_rd(4'h0, rd);
    chk(rd, 32'h83);
    bus_rd(4'h8, rd);
    chk(rd, 32'h3);
    bus_rd(4'h4, rd);
    chk(rd, 32'h0);
    $display("test reset done");
  endtask
  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run is under a thousand cycles; this leaves wide margin
  initial begin
    #200000;
    failures++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    acc_valid = 1'b0;
    acc_kind = 2'h0;
    acc_addr = 21'h0;
    data_req = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    test_regs();
    test_routes();
    test_wait();
    chk(32'(n_acc), 32'(ext_exp));
    chk(32'(n_wr), 32'(wr_exp));
    test_reset();
    conclude();
  end
endmodule
